// *** src/tcr_pkg.sv ***
// Package with register map, field positions and timing counts of the timer
package tcr_pkg;
    // Register indices; the bus byte address is four times the index
    localparam logic [7:0] IDX_MAIN   = 8'hc8;
    localparam logic [7:0] IDX_MODE   = 8'hc9;
    localparam logic [7:0] IDX_CNT_L  = 8'hca;
    localparam logic [7:0] IDX_CNT_H  = 8'hcb;
    localparam logic [7:0] IDX_RLD_L  = 8'hcc;
    localparam logic [7:0] IDX_RLD_H  = 8'hcd;
    localparam logic [7:0] IDX_SER    = 8'hce;
    // Main control field positions
    localparam int B_OVF  = 7;
    localparam int B_EXT  = 6;
    localparam int B_RCLK = 5;
    localparam int B_TX_CLOCK_SELECT = 4;
    localparam int B_EXEN = 3;
    localparam int B_RUN  = 2;
    localparam int B_CSEL = 1;
    localparam int B_CPRL = 0;
    // Mode control field positions
    localparam int B_CKOE = 1;
    localparam int B_DOWN_COUNT_ENABLE = 0;
    localparam logic [7:0] MODE_MASK = 8'h03;
    localparam logic [7:0] RST_MAIN  = 8'h00;
    localparam logic [7:0] RST_MODE  = 8'h00;
    // Oscillator periods per machine cycle and per state time
    localparam int OSC_PER_MC = 12;
    localparam int OSC_PER_ST = 2;
    localparam logic [3:0] MC_LAST = 4'(OSC_PER_MC - 1);
    localparam logic [3:0] BAUD_DIV = 4'hf;  // Overflows per serial bit-1
    localparam logic [15:0] ALL_ONES = 16'hffff;
endpackage : tcr_pkg

// *** src/tcr_timer.sv ***
// Sixteen-bit timer/counter with capture, auto-reload and baud generation
// Behaviour
// RULE1: overflow flag sets on overflow, sticky, never set in baud mode
// RULE2: ext flag sets on trigger-pin capture/reload when trigger enabled
// RULE3: ext flag raises no interrupt while down-count enabled
// RULE4: receive clock select picks our overflows, else other timer's
// RULE5: transmit clock select picks our overflows, else other timer's
// RULE6: trigger ignored when disabled; edges reload or capture only outside baud mode
// RULE7: counts only while run control is 1
// RULE8: counter select 0 counts internal timing, 1 counts pin edges
// RULE9: baud mode ignores capture/reload select, reloads on overflow
// RULE10: capture copies count into reload pair and sets ext flag
// RULE11: down-count enable clears to 0 at reset
// RULE12: up auto-reload overflows at ffff, sets flag, reloads pair
// RULE13: up auto-reload trigger edge reloads and sets ext flag
// RULE14: up/down with pin high counts up, overflow reloads pair
// RULE15: up/down with pin low counts down, underflow at pair loads ffff
// RULE16: up/down toggles ext flag on each over/underflow
// RULE17: baud mode rollover reloads count from reload pair
// RULE18: timer ticks per machine cycle, baud mode per state time
// RULE19: serial bit rate is overflow rate divided by sixteen
// RULE20: baud mode trigger edge sets ext flag without reload
// RULE21: software stops timer before touching count or reload in baud mode
// RULE22: mode register holds output enable bit1, down enable bit0
// RULE23: count pin sampled once per machine cycle, high then low counts
// RULE24: trigger pin sampled likewise for falling edge detection
`timescale 1ns/100ps
module tcr_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        count_input_pin,
    input  wire logic        ext_trigger_pin,
    input  wire logic        other_timer_ovf,
    output logic             rx_baud_tick,
    output logic             tx_baud_tick,
    output logic             timer_irq
);
    // Registers
    logic [7:0]  main_ctl;
    logic [7:0]  mode_ctl;
    logic [15:0] count;
    logic [15:0] reload;
    logic [3:0]  osc_div;
    logic        cnt_smp;
    logic        cnt_prev;
    logic        trg_smp;
    logic        trg_prev;
    logic        wr_pend;
    logic        rd_ph;
    logic [7:0]  wr_idx;
    logic [3:0]  rx_div;
    logic [3:0]  tx_div;
    logic        rx_src_q;
    logic        tx_src_q;
    logic        rx_src_d;
    logic        tx_src_d;

    // Decoded modes
    wire baud_mode = main_ctl[tcr_pkg::B_RCLK] | main_ctl[tcr_pkg::B_TX_CLOCK_SELECT];
    wire run       = main_ctl[tcr_pkg::B_RUN];
    wire down_count_enable      = mode_ctl[tcr_pkg::B_DOWN_COUNT_ENABLE];
    wire capture   = main_ctl[tcr_pkg::B_CPRL] & ~baud_mode;     // RULE9
    wire exen      = main_ctl[tcr_pkg::B_EXEN];

    // Machine-cycle strobe and state-time strobe from the oscillator
    wire mc_tick = (osc_div == tcr_pkg::MC_LAST);
    wire st_tick = osc_div[0];
    // Pin samples taken once per machine cycle
    wire cnt_edge = cnt_prev & ~cnt_smp;                          // RULE23
    wire trg_edge = trg_prev & ~trg_smp & exen;            // RULE24 RULE6
    wire int_tick = baud_mode ? st_tick : mc_tick;                // RULE18
    wire tick = run & (main_ctl[tcr_pkg::B_CSEL] ? (cnt_edge & mc_tick)
                                                 : int_tick); // RULE7 RULE8
    // Direction, rollover and underflow
    wire down    = down_count_enable & ~capture & ~baud_mode & ~ext_trigger_pin;
    wire updown  = down_count_enable & ~capture & ~baud_mode;
    wire ovf     = tick & ~down & (count == tcr_pkg::ALL_ONES);
    wire unf     = tick & down & (count == reload);              // RULE15
    wire roll    = ovf | unf;
    // Trigger acts on a machine-cycle boundary only
    wire trg_act = trg_edge & mc_tick;
    wire trg_reload  = trg_act & ~capture & ~updown & ~baud_mode; // RULE13
    wire trg_capture = trg_act & capture;                         // RULE10

    // Bus decode
    wire        bus_go  = hsel & hready & htrans[1];
    wire [7:0]  addr_ix = haddr[9:2];
    wire        wr_main = wr_pend & (wr_idx == tcr_pkg::IDX_MAIN);
    wire        wr_mode = wr_pend & (wr_idx == tcr_pkg::IDX_MODE);
    wire        wr_cl   = wr_pend & (wr_idx == tcr_pkg::IDX_CNT_L);
    wire        wr_ch   = wr_pend & (wr_idx == tcr_pkg::IDX_CNT_H);
    wire        wr_rl   = wr_pend & (wr_idx == tcr_pkg::IDX_RLD_L);
    wire        wr_rh   = wr_pend & (wr_idx == tcr_pkg::IDX_RLD_H);

    // Register read mux, unmapped addresses read zero
    function automatic logic [7:0] rd_mux(input logic [7:0] ix,
                                          input logic [7:0] mc,
                                          input logic [7:0] md,
                                          input logic [15:0] c,
                                          input logic [15:0] r,
                                          input logic [1:0]  s);
        case (ix)
            tcr_pkg::IDX_MAIN:  rd_mux = mc;
            tcr_pkg::IDX_MODE:  rd_mux = md & tcr_pkg::MODE_MASK;  // RULE22
            tcr_pkg::IDX_CNT_L: rd_mux = c[7:0];
            tcr_pkg::IDX_CNT_H: rd_mux = c[15:8];
            tcr_pkg::IDX_RLD_L: rd_mux = r[7:0];
            tcr_pkg::IDX_RLD_H: rd_mux = r[15:8];
            tcr_pkg::IDX_SER:   rd_mux = {6'h00, s};
            default:            rd_mux = 8'h00;
        endcase
    endfunction : rd_mux

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Oscillator divider; rolls every machine cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_div <= 4'h0;
        end else begin
            osc_div <= mc_tick ? 4'h0 : osc_div + 4'h1;
        end
    end

    // Pin samples once per machine cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_smp  <= 1'b0;
            cnt_prev <= 1'b0;
            trg_smp  <= 1'b0;
            trg_prev <= 1'b0;
        end else if (mc_tick) begin
            cnt_smp  <= count_input_pin;                          // RULE23
            cnt_prev <= cnt_smp;
            trg_smp  <= ext_trigger_pin;                          // RULE24
            trg_prev <= trg_smp;
        end
    end

    // Bus address phase capture; writes land one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_ph   <= 1'b0;
            wr_idx  <= 8'h00;
        end else begin
            wr_pend <= bus_go & hwrite;
            rd_ph   <= bus_go & ~hwrite;
            wr_idx  <= addr_ix;
        end
    end

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (bus_go & ~hwrite) begin
            hrdata <= {24'h0, rd_mux(addr_ix, main_ctl, mode_ctl, count,
                                     reload, {rx_src_q, tx_src_q})};
        end
    end

    // Mode register; down-count clears at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ctl <= tcr_pkg::RST_MODE;                        // RULE11
        end else if (wr_mode) begin
            mode_ctl <= hwdata[7:0] & tcr_pkg::MODE_MASK;         // RULE22
        end
    end

    // Main control: hardware set wins over a software clear in one cycle
    logic next_ovf;
    logic next_ext;
    always_comb begin
        next_ovf = wr_main ? hwdata[tcr_pkg::B_OVF] : main_ctl[tcr_pkg::B_OVF];
        next_ext = wr_main ? hwdata[tcr_pkg::B_EXT] : main_ctl[tcr_pkg::B_EXT];
        if (roll & ~baud_mode)
            next_ovf = 1'b1;                               // RULE1 RULE12
        if (updown & roll)
            next_ext = ~main_ctl[tcr_pkg::B_EXT];                 // RULE16
        else if (trg_act & ~updown)
            next_ext = 1'b1;                        // RULE2 RULE10 RULE20
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_ctl <= tcr_pkg::RST_MAIN;
        end else begin
            main_ctl <= wr_main ? hwdata[7:0] : main_ctl;
            main_ctl[tcr_pkg::B_OVF] <= next_ovf;
            main_ctl[tcr_pkg::B_EXT] <= next_ext;
        end
    end

    // Counter with reload, capture and underflow handling
    logic [15:0] next_count;
    always_comb begin
        next_count = count;
        if (wr_cl)
            next_count[7:0] = hwdata[7:0];
        if (wr_ch)
            next_count[15:8] = hwdata[7:0];
        if (unf)
            next_count = tcr_pkg::ALL_ONES;                       // RULE15
        else if (ovf & ~capture)
            next_count = reload;                     // RULE12 RULE14 RULE17
        else if (trg_reload)
            next_count = reload;                                  // RULE13
        else if (tick)
            next_count = down ? count - 16'h1 : count + 16'h1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 16'h0;
        end else begin
            count <= next_count;
        end
    end

    // Reload pair; capture takes the live count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload <= 16'h0;
        end else if (trg_capture) begin
            reload <= count;                                      // RULE10
        end else begin
            if (wr_rl)
                reload[7:0] <= hwdata[7:0];
            if (wr_rh)
                reload[15:8] <= hwdata[7:0];
        end
    end

    // Serial clock source selection, each side divided by sixteen
    assign rx_src_d = main_ctl[tcr_pkg::B_RCLK] ? ovf : other_timer_ovf; // RULE4
    assign tx_src_d = main_ctl[tcr_pkg::B_TX_CLOCK_SELECT] ? ovf : other_timer_ovf; // RULE5

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_div       <= 4'h0;
            tx_div       <= 4'h0;
            rx_src_q     <= 1'b0;
            tx_src_q     <= 1'b0;
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
        end else begin
            rx_src_q     <= rx_src_d;
            tx_src_q     <= tx_src_d;
            rx_div       <= rx_src_d ? rx_div + 4'h1 : rx_div;    // RULE19
            tx_div       <= tx_src_d ? tx_div + 4'h1 : tx_div;    // RULE19
            rx_baud_tick <= rx_src_d & (rx_div == tcr_pkg::BAUD_DIV);
            tx_baud_tick <= tx_src_d & (tx_div == tcr_pkg::BAUD_DIV);
        end
    end

    // Interrupt request; ext flag is silent in up/down mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= main_ctl[tcr_pkg::B_OVF] |
                         (main_ctl[tcr_pkg::B_EXT] & ~down_count_enable);      // RULE3
        end
    end
endmodule : tcr_timer

// *** test/tcr_timer_props.sv ***
// Checker of bus answers, readback and output pulses of the timer
`timescale 1ns/100ps
module tcr_timer_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rx_baud_tick,
    input wire logic        tx_baud_tick,
    input wire logic        timer_irq
);
    logic       ph_w;
    logic       ph_r;
    logic [7:0] ph_i;
    logic [7:0] main_sh;
    logic [7:0] mode_sh;
    wire        take = hsel & hready & htrans[1];
    // Shadow of software-written control bits, to compare readback
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_w <= 1'b0;
            ph_r <= 1'b0;
            ph_i <= 8'h00;
            main_sh <= 8'h00;
            mode_sh <= 8'h00;
        end else begin
            ph_w <= take & hwrite;
            ph_r <= take & ~hwrite;
            ph_i <= haddr[9:2];
            if (ph_w && ph_i == tcr_pkg::IDX_MAIN) main_sh <= hwdata[7:0];
            if (ph_w && ph_i == tcr_pkg::IDX_MODE)
                mode_sh <= hwdata[7:0] & tcr_pkg::MODE_MASK;
        end
    end
    // Baud mode with trigger off and flags cleared: nothing may interrupt
    wire quiet = (main_sh[5] | main_sh[4]) & ~main_sh[3] & ~main_sh[7]
                 & ~main_sh[6];
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_READY: assert property (hreadyout) else $error("wait state seen");
    AST_OKAY: assert property (!hresp) else $error("error response seen");
    AST_RX_GAP: assert property (rx_baud_tick |=> !rx_baud_tick [*8])
        else $error("receive tick too close");
    AST_TX_GAP: assert property (tx_baud_tick |=> !tx_baud_tick [*8])
        else $error("transmit tick too close");
    AST_HI_ZERO: assert property (ph_r |-> hrdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    AST_MODE_RB: assert property (ph_r && ph_i == tcr_pkg::IDX_MODE
        |-> hrdata[7:0] == $past(mode_sh)) else $error("mode readback");
    AST_MAIN_RB: assert property (ph_r && ph_i == tcr_pkg::IDX_MAIN
        |-> hrdata[5:0] == $past(main_sh[5:0])) else $error("main readback");
    AST_IRQ_BAUD: assert property (quiet && $past(quiet) |-> !timer_irq)
        else $error("interrupt in quiet baud mode");
    AST_IRQ_RST: assert property ($rose(hresetn) |-> !timer_irq)
        else $error("interrupt out of reset");
endmodule : tcr_timer_chk
bind tcr_timer tcr_timer_chk chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .timer_irq(timer_irq));

// *** test/tcr_serial_model.sv ***
// Model of the serial port and of the other timer that may clock it
`timescale 1ns/100ps
module tcr_serial_model #(
    parameter int OVF_GAP = 20
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic rx_baud_tick,
    input  wire logic tx_baud_tick,
    output logic      other_timer_ovf,
    output int        rx_gap,
    output int        tx_gap
);
    int div;
    int rx_n;
    int tx_n;
    // Other timer overflows; serial side measures bit-clock spacing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div <= 0;
            rx_n <= 0;
            tx_n <= 0;
            other_timer_ovf <= 1'b0;
        end else begin
            div <= (div == OVF_GAP - 1) ? 0 : div + 1;
            other_timer_ovf <= (div == 0);
            rx_n <= rx_baud_tick ? 0 : rx_n + 1;
            tx_n <= tx_baud_tick ? 0 : tx_n + 1;
            if (rx_baud_tick) rx_gap <= rx_n + 1;
            if (tx_baud_tick) tx_gap <= tx_n + 1;
        end
    end
endmodule : tcr_serial_model

// *** test/testbench.sv ***
// Self-checking bench of the timer through its register bus
`timescale 1ns/100ps
module testbench;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        trig = 1'b1;
    logic        cnt_pin = 1'b1;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        ovf2;
    logic        rx_t;
    logic        tx_t;
    logic        irq;
    logic [7:0]  d;
    int          rx_gap;
    int          tx_gap;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cyc = 0;
    tcr_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .count_input_pin(cnt_pin),
        .ext_trigger_pin(trig), .other_timer_ovf(ovf2),
        .rx_baud_tick(rx_t), .tx_baud_tick(tx_t), .timer_irq(irq));
    tcr_serial_model ser (.hclk(hclk), .hresetn(hresetn), .rx_baud_tick(rx_t),
        .tx_baud_tick(tx_t), .other_timer_ovf(ovf2), .rx_gap(rx_gap),
        .tx_gap(tx_gap));
    always #25 hclk = ~hclk;
    task automatic stop_test;
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    // Hang guard, well above the longest scenario mix
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // One single transfer: address phase, then data phase, each until ready
    task automatic xfer(input logic w, input logic [7:0] i,
                        input logic [7:0] wd, output logic [7:0] rd);
        haddr <= {22'h0, i, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask : xfer
    task automatic wr(input logic [7:0] i, input logic [7:0] wd);
        xfer(1'b1, i, wd, d);
    endtask : wr
    task automatic rd(input logic [7:0] i);
        xfer(1'b0, i, 8'h00, d);
    endtask : rd
    // Poll the main register until a flag bit shows, bounded
    task automatic poll(input logic [7:0] m);
        repeat (300) begin
            rd(tcr_pkg::IDX_MAIN);
            if ((d & m) == m) break;
        end
        chk("flag", m, d & m);
    endtask : poll
    task automatic t_regs;
        rd(tcr_pkg::IDX_MODE);
        chk("mode reset", 8'h00, d);
        wr(tcr_pkg::IDX_MODE, 8'hff);
        rd(tcr_pkg::IDX_MODE);
        chk("mode bits", 8'h03, d);
        wr(8'hff, 8'h5a);
        rd(8'hff);
        chk("unmapped", 8'h00, d);
        wr(tcr_pkg::IDX_MODE, 8'h00);
    endtask : t_regs
    task automatic load(input logic [15:0] rl, input logic [15:0] c);
        wr(tcr_pkg::IDX_RLD_L, rl[7:0]);
        wr(tcr_pkg::IDX_RLD_H, rl[15:8]);
        wr(tcr_pkg::IDX_CNT_L, c[7:0]);
        wr(tcr_pkg::IDX_CNT_H, c[15:8]);
    endtask : load
    task automatic t_up;
        logic [7:0] c0;
        load(16'hfff0, 16'hfffe);
        wr(tcr_pkg::IDX_MAIN, 8'h04);
        poll(8'h80);
        rd(tcr_pkg::IDX_MAIN);
        chk("flag sticky", 8'h80, d & 8'h80);
        chk("irq", 1'b1, irq);
        wr(tcr_pkg::IDX_MAIN, 8'h00);
        rd(tcr_pkg::IDX_CNT_H);
        chk("reloaded high", 8'hff, d);
        rd(tcr_pkg::IDX_CNT_L);
        c0 = d;
        repeat (40) @(posedge hclk);
        rd(tcr_pkg::IDX_CNT_L);
        chk("stopped", c0, d);
    endtask : t_up
    // Counter function: each pin level held two machine cycles
    task automatic t_count;
        load(16'h0000, 16'h0000);
        wr(tcr_pkg::IDX_MAIN, 8'h06);
        repeat (3) begin
            cnt_pin <= 1'b0;
            repeat (24) @(posedge hclk);
            cnt_pin <= 1'b1;
            repeat (24) @(posedge hclk);
        end
        wr(tcr_pkg::IDX_MAIN, 8'h00);
        rd(tcr_pkg::IDX_CNT_L);
        chk("pin count", 16'h0003, d);
    endtask : t_count
    task automatic t_capture;
        load(16'h0000, 16'h1200);
        wr(tcr_pkg::IDX_MAIN, 8'h05);
        trig <= 1'b0;
        repeat (40) @(posedge hclk);
        rd(tcr_pkg::IDX_MAIN);
        chk("trigger off", 8'h00, d & 8'h40);
        trig <= 1'b1;
        wr(tcr_pkg::IDX_MAIN, 8'h0d);
        repeat (30) @(posedge hclk);
        trig <= 1'b0;
        repeat (40) @(posedge hclk);
        rd(tcr_pkg::IDX_MAIN);
        chk("ext flag", 8'h40, d & 8'h40);
        chk("irq ext", 1'b1, irq);
        rd(tcr_pkg::IDX_RLD_H);
        chk("capture high", 8'h12, d);
        trig <= 1'b1;
        wr(tcr_pkg::IDX_MAIN, 8'h00);
    endtask : t_capture
    task automatic t_baud;
        load(16'hfff0, 16'hfff0);
        wr(tcr_pkg::IDX_MAIN, 8'h3c);
        repeat (30) @(posedge hclk);
        trig <= 1'b0;
        repeat (1200) @(posedge hclk);
        chk("tx rate", 16'd512, tx_gap[15:0]);
        chk("rx rate", 16'd512, rx_gap[15:0]);
        rd(tcr_pkg::IDX_MAIN);
        chk("baud flags", 8'h40, d & 8'hc0);
        trig <= 1'b1;
        wr(tcr_pkg::IDX_MAIN, 8'h14);
        repeat (1100) @(posedge hclk);
        chk("rx other", 16'd320, rx_gap[15:0]);
        chk("tx own", 16'd512, tx_gap[15:0]);
        chk("irq baud", 1'b0, irq);
        wr(tcr_pkg::IDX_MAIN, 8'h00);
    endtask : t_baud
    task automatic t_down;
        wr(tcr_pkg::IDX_MODE, 8'h01);
        trig <= 1'b0;
        load(16'h1000, 16'h1002);
        wr(tcr_pkg::IDX_MAIN, 8'h04);
        poll(8'h80);
        chk("ext toggled", 8'h40, d & 8'h40);
        wr(tcr_pkg::IDX_MAIN, 8'h00);
        rd(tcr_pkg::IDX_CNT_H);
        chk("underflow load", 8'hff, d);
        wr(tcr_pkg::IDX_MAIN, 8'h40);
        repeat (4) @(posedge hclk);
        chk("irq down", 1'b0, irq);
    endtask : t_down
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_up();
        t_count();
        t_capture();
        t_baud();
        t_down();
        stop_test();
    end
endmodule : testbench
